// *** hdl/ctr_cycle_regs.sv ***
// Cycle timing register bank with its command timing engine.
// Assumes I/O strobes are single-cycle pulses synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module ctr_cycle_regs
    import ctr_pkg::*;
(
    input  wire logic       ref_clk,           // 50 MHz clock
    input  wire logic       rst_b,             // Async reset, low
    input  wire logic [7:0] io_addr,           // I/O port address
    input  wire logic [7:0] io_wdata,          // I/O write data
    input  wire logic       io_wr,             // I/O write strobe
    input  wire logic       io_rd,             // I/O read strobe
    output logic      [1:0] rd_data_hi,        // Read data bits 7:6
    output logic            rd_data_oe,        // Drives bits 7:6
    input  wire logic       parity_err,        // Parity fail pulse
    input  wire logic       chan_check,        // Channel check level
    output logic            nmi_out,           // NMI to processor
    output logic      [1:0] cpu_speed_sel,     // Processor clock rate
    output logic      [1:0] dma_speed_sel,     // Transfer clock rate
    output logic            main_clk_en,       // Main clocks running
    output logic            aux_clk_en,        // Timer/copro/kbd clocks
    input  wire logic       copro_busy_b,      // Coprocessor busy, low
    input  wire logic       copro_error_b,     // Coprocessor error, low
    output logic            cpu_busy_out_b,    // Busy to processor
    output logic            copro_reset,       // Coprocessor reset
    input  wire logic       cyc_start,         // Local latch strobe
    input  wire logic       cyc_mem,           // Memory, else I/O
    input  wire logic       cyc_read,          // Read, else write
    input  wire logic       local_board_select,// On-board cycle
    input  wire logic       mem_wide_select,   // 16-bit memory
    input  wire logic       io_wide_select,    // 16-bit I/O
    input  wire logic       zero_wait_request, // Early end request
    input  wire logic       channel_ready,     // Ready, low stretches
    output logic            bus_latch_strobe,  // Bus address latch
    output logic            bus_mem_read,      // Memory read command
    output logic            bus_mem_write,     // Memory write command
    output logic            bus_io_read,       // I/O read command
    output logic            bus_io_write,      // I/O write command
    output logic            cyc_ready          // Cycle end pulse
);
    // ========================================================
    // Decode
    function automatic logic [5:0] ws_clocks(input logic [3:0] ws);
        ws_clocks = {1'b0, ws, 1'b0};
    endfunction

    logic [7:0]  err_mask_reg;
    logic [7:0]  speed_reg;
    logic        nmi_dis_reg;
    logic [3:0]  index_reg;
    logic [3:0]  tr_reg [TR_NUM];
    logic        par_lat_reg;
    logic        chk_lat_reg;
    logic        busy_lat_reg;
    logic [2:0]  cp_cnt_reg;
    logic [1:0]  rd_hi_reg;
    logic        rd_oe_reg;
    ctr_state_e  st_reg;
    ctr_state_e  st_next;
    logic [5:0]  tick_reg;
    logic [5:0]  cnt_reg;
    logic [5:0]  cnt_next;
    logic        read_reg;
    logic        mem_reg;
    logic [5:0]  waited_reg;

    wire wr_err   = io_wr && (io_addr == ADDR_ERR_CTL);
    wire wr_speed = io_wr && (io_addr == ADDR_SPEED);
    wire wr_nmi   = io_wr && (io_addr == ADDR_NMI_MASK);
    wire wr_ptr   = io_wr && (io_addr == ADDR_POINTER);
    wire wr_tr    = io_wr && (io_addr == ADDR_TIMING);
    wire wr_bclr  = io_wr && (io_addr == ADDR_BSY_CLR);
    wire wr_cprst = io_wr && (io_addr == ADDR_CP_RST);
    wire rd_err   = io_rd && (io_addr == ADDR_ERR_CTL);
    wire unlocked = !speed_reg[SPD_LOCK_BIT];
    wire spd_upd  = wr_speed && unlocked && !io_wdata[SPD_LOCK_BIT];
    wire ix_used  = (index_reg < 4'(TR_NUM))
                 && (index_reg != IX_UNUSED_A)
                 && (index_reg != IX_UNUSED_B);
    wire tr_upd   = wr_tr && unlocked && ix_used;
    wire par_dis  = err_mask_reg[ERR_PAR_DIS_BIT];
    wire chk_dis  = err_mask_reg[ERR_CHK_DIS_BIT];
    wire par_rean = wr_err && par_dis && !io_wdata[ERR_PAR_DIS_BIT];
    wire chk_rean = wr_err && chk_dis && !io_wdata[ERR_CHK_DIS_BIT];
    wire cp_err   = !copro_error_b && !copro_busy_b;

    // ========================================================
    // Software registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            err_mask_reg <= ERR_MASK_RST;
            speed_reg    <= SPEED_RST;
            nmi_dis_reg  <= NMI_DIS_RST;
            index_reg    <= IX_BL_DLY;
        end else begin
            if (wr_err)
                err_mask_reg <= io_wdata;
            if (spd_upd)
                speed_reg <= io_wdata;
            else if (wr_speed)
                speed_reg[SPD_LOCK_BIT] <= io_wdata[SPD_LOCK_BIT];
            if (wr_nmi)
                nmi_dis_reg <= io_wdata[NMI_DIS_BIT];
            if (wr_ptr)
                index_reg <= {io_wdata[7:6], io_wdata[3:2]};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < TR_NUM; i++)
                tr_reg[i] <= TR_RST[4*i +: 4];
        end else if (tr_upd) begin
            tr_reg[index_reg] <= io_wdata[3:0];
        end
    end

    // ========================================================
    // Error latches, coprocessor busy and reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            par_lat_reg  <= 1'b0;
            chk_lat_reg  <= 1'b0;
            busy_lat_reg <= 1'b0;
            cp_cnt_reg   <= '0;
            rd_hi_reg    <= '0;
            rd_oe_reg    <= 1'b0;
        end else begin
            // Set wins over the re-enable clear
            if (parity_err)
                par_lat_reg <= 1'b1;
            else if (par_rean)
                par_lat_reg <= 1'b0;
            if (chan_check)
                chk_lat_reg <= 1'b1;
            else if (chk_rean)
                chk_lat_reg <= 1'b0;
            if (cp_err)
                busy_lat_reg <= 1'b1;
            else if (wr_bclr || copro_reset)
                busy_lat_reg <= 1'b0;
            if (wr_cprst)
                cp_cnt_reg <= CP_RST_LEN;
            else if (cp_cnt_reg != '0)
                cp_cnt_reg <= cp_cnt_reg - 3'h1;
            rd_oe_reg <= rd_err;
            rd_hi_reg <= {par_lat_reg, chk_lat_reg};
        end
    end

    assign rd_data_hi     = rd_hi_reg;
    assign rd_data_oe     = rd_oe_reg;
    assign nmi_out        = !nmi_dis_reg
                          && ((par_lat_reg && !par_dis)
                          ||  (chk_lat_reg && !chk_dis));
    assign cpu_busy_out_b = copro_busy_b && !busy_lat_reg;
    assign copro_reset    = (cp_cnt_reg != '0);
    assign cpu_speed_sel  = speed_reg[SPD_CPU_HI:SPD_CPU_LO];
    assign dma_speed_sel  = speed_reg[SPD_DMA_HI:SPD_DMA_LO];
    assign main_clk_en    = !speed_reg[SPD_STOP_BIT];
    assign aux_clk_en     = 1'b1;

    // ========================================================
    // Cycle class selection
    wire lcl     = local_board_select;
    wire w_mem   = cyc_mem && mem_wide_select;
    wire w_io    = !cyc_mem && io_wide_select;
    wire fast    = (cpu_speed_sel == CPU_SPEED_FAST);
    wire [3:0] lcl_ws  = cyc_read ? tr_reg[IX_LRD_WS]
                                  : tr_reg[IX_LWR_WS];
    wire [3:0] sel_dly = lcl ? (cyc_mem ? 4'h0
                                        : tr_reg[IX_LIO_CMD])
                       : w_mem ? tr_reg[IX_WMEM_CMD]
                       : tr_reg[IX_N_CMD];
    wire [3:0] sel_ws  = lcl   ? lcl_ws
                       : w_mem ? tr_reg[IX_WMEM_WS]
                       : w_io  ? tr_reg[IX_WIO_WS]
                       : tr_reg[IX_N_WS];
    wire [5:0] sel_wait = ws_clocks(sel_ws)
                        + (fast ? SYNC_EXTRA : 6'h0);
    wire [5:0] zw_min   = ws_clocks(tr_reg[IX_ZW_MIN]);
    wire [5:0] bl_dly   = {2'b00, tr_reg[IX_BL_DLY] & TR_MASK2};
    wire [3:0] bl_w4    = tr_reg[IX_BL_WID] & TR_MASK2;
    wire [5:0] bl_wid   = {2'b00, (bl_w4 < BL_WID_MIN) ? BL_WID_MIN
                                                        : bl_w4};

    // ========================================================
    // Command timing engine
    wire zw_end = zero_wait_request && (waited_reg >= zw_min);
    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            CTR_IDLE: begin
                cnt_next = 6'h0;
                if (cyc_start) begin
                    st_next  = (sel_dly == 4'h0) ? CTR_CMD : CTR_DELAY;
                    cnt_next = {2'b00, sel_dly};
                    if (sel_dly == 4'h0)
                        cnt_next = sel_wait;
                end
            end
            CTR_DELAY: begin
                cnt_next = cnt_reg - 6'h1;
                if (cnt_reg == 6'h1) begin
                    st_next  = CTR_CMD;
                    cnt_next = sel_wait;
                end
            end
            CTR_CMD: begin
                if (cnt_reg != 6'h0)
                    cnt_next = cnt_reg - 6'h1;
                if (zw_end || cnt_reg == 6'h0)
                    st_next = CTR_HOLD;
            end
            CTR_HOLD: begin
                if (channel_ready)
                    st_next = CTR_DONE;
            end
            CTR_DONE: begin
                st_next = CTR_IDLE;
            end
            default: begin
                st_next = CTR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg   <= CTR_IDLE;
            cnt_reg  <= '0;
            tick_reg <= '0;
            read_reg <= 1'b0;
            mem_reg  <= 1'b0;
            waited_reg <= '0;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            if (st_reg == CTR_IDLE) begin
                tick_reg <= '0;
                read_reg <= cyc_read;
                mem_reg  <= cyc_mem;
            end else if (tick_reg != 6'h3F) begin
                tick_reg <= tick_reg + 6'h1;
            end
            if (st_reg != CTR_CMD)
                waited_reg <= '0;
            else if (waited_reg != 6'h3F)
                waited_reg <= waited_reg + 6'h1;
        end
    end

    wire busy_cyc = (st_reg != CTR_IDLE);
    wire cmd_on   = (st_reg == CTR_CMD) || (st_reg == CTR_HOLD);
    assign bus_latch_strobe = busy_cyc && (tick_reg >= bl_dly)
                           && (tick_reg < bl_dly + bl_wid);
    assign bus_mem_read  = cmd_on &&  mem_reg &&  read_reg;
    assign bus_mem_write = cmd_on &&  mem_reg && !read_reg;
    assign bus_io_read   = cmd_on && !mem_reg &&  read_reg;
    assign bus_io_write  = cmd_on && !mem_reg && !read_reg;
    assign cyc_ready     = (st_reg == CTR_DONE);

    // ========================================================
    // Checks
    sequence s_wait_clear;
        wr_bclr && !cp_err;
    endsequence
    property p_busy_release;
        @(posedge ref_clk) disable iff (!rst_b)
        s_wait_clear ##1 (copro_busy_b && !cp_err)
            |-> cpu_busy_out_b;
    endproperty
    a_busy_release: assert property (p_busy_release)
        else $error("busy latch not released");

    a_cp_reset_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_cprst |=> copro_reset [*4])
        else $error("coprocessor reset pulse short");

    a_lock_holds_speed: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_speed && io_wdata[SPD_LOCK_BIT])
            |=> $stable(cpu_speed_sel) && $stable(main_clk_en))
        else $error("speed changed with top bit set");

    a_stop_clock: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (spd_upd && io_wdata[SPD_STOP_BIT]) |=> !main_clk_en && aux_clk_en)
        else $error("clock stop not applied");

    a_read_lanes: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        rd_err |=> rd_data_oe ##1 !rd_data_oe || $past(rd_err))
        else $error("read lanes drive wrong");

    a_parity_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (par_rean && !parity_err) |=> !par_lat_reg)
        else $error("parity latch not cleared");

    a_unused_index: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_tr && !ix_used) |=> $stable(tr_reg[IX_N_WS])
            && $stable(tr_reg[IX_BL_DLY]))
        else $error("unused index changed timing");

    a_nmi_masked: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        nmi_dis_reg |-> !nmi_out)
        else $error("NMI passed while masked");

    a_local_mem_nodly: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (st_reg == CTR_IDLE && cyc_start && lcl && cyc_mem)
            |=> st_reg == CTR_CMD)
        else $error("local memory cycle delayed");

    a_latch_first: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (st_reg == CTR_IDLE && cyc_start && bl_dly == 6'h0)
            |=> bus_latch_strobe)
        else $error("latch strobe missing");

    a_hold_stretch: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (st_reg == CTR_HOLD && !channel_ready)
            |=> cmd_on && !cyc_ready)
        else $error("not-ready did not stretch cycle");

    a_zero_wait_min: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (st_reg == CTR_CMD && cnt_reg != 6'h0 && waited_reg < zw_min)
            |=> st_reg == CTR_CMD)
        else $error("zero-wait ended cycle early");

    a_read_idle: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !rd_err |=> !rd_data_oe)
        else $error("read lanes driven without read");
endmodule
`default_nettype wire

// *** hdl/ctr_pkg.sv ***
// Constants for the cycle timing register block.
// Assumes one 50 MHz clock and single-cycle I/O write/read strobes.
//
// Notes on behaviour
// - Error port holds parity and channel check masks; reads return both error latches.
// - Speed port sets clock rates, clock stop and the lock bit.
// - Speed or stop changes only when unlocked and top data bit is low.
// - Clock stop halts main clocks; timer, coprocessor, keyboard clocks run.
// - Reset clears speed bits 2, 3, 6 and sets bit 7.
// - Write-only NMI mask port; its top bit is set at power-up.
// - Pointer bits 7, 6, 3, 2 select the timing register next loaded.
// - Register 0 delays bus latch strobe 0 to 3 clocks; default 0.
// - Register 1 sets bus latch strobe width 1 to 3 clocks; default 1.
// - Register 3 is narrow memory and all off-board I/O command delay; default 1.
// - Register 4 is wait states for narrow operations; default 4.
// - Register 5 is wait states for wide I/O cycles; default 1.
// - Registers 6 and 7 are wide memory delay and waits; 0 and 1.
// - Register 8 is least wait states before zero-wait may end a cycle.
// - Local board cycles: no memory command delay, waits from registers 9 or 10.
// - Register 12 is local I/O delay; not-ready input stretches the waits.
// - Each wait state lasts two clocks.
// - Fast clock mode may add one wait state for synchronisation.
// - Any write to busy-clear port releases the latched busy output.
// - Write to coprocessor reset port pulses the coprocessor reset.
// - Error port read drives only data bits 6 and 7.
// - Parity latch clears when its mask is disabled then re-enabled.
package ctr_pkg;
    // ========================================================
    // Port addresses
    localparam logic [7:0] ADDR_ERR_CTL  = 8'h61;
    localparam logic [7:0] ADDR_SPEED    = 8'h63;
    localparam logic [7:0] ADDR_NMI_MASK = 8'h70;
    localparam logic [7:0] ADDR_POINTER  = 8'h72;
    localparam logic [7:0] ADDR_TIMING   = 8'h73;
    localparam logic [7:0] ADDR_BSY_CLR  = 8'hF0;
    localparam logic [7:0] ADDR_CP_RST   = 8'hF1;
    // ========================================================
    // Field positions
    localparam int ERR_PAR_DIS_BIT = 2;
    localparam int ERR_CHK_DIS_BIT = 3;
    localparam int ERR_PAR_ST_BIT  = 7;
    localparam int ERR_CHK_ST_BIT  = 6;
    localparam int SPD_LOCK_BIT    = 7;
    localparam int SPD_STOP_BIT    = 6;
    localparam int SPD_CPU_LO      = 2;
    localparam int SPD_CPU_HI      = 3;
    localparam int SPD_DMA_LO      = 0;
    localparam int SPD_DMA_HI      = 1;
    localparam int NMI_DIS_BIT     = 7;
    localparam logic [1:0] CPU_SPEED_FAST = 2'h1;
    // ========================================================
    // Reset values
    localparam logic [7:0] SPEED_RST    = 8'h80;
    localparam logic [7:0] ERR_MASK_RST = 8'h0C;
    localparam logic       NMI_DIS_RST  = 1'b1;
    // ========================================================
    // Timing register indexes and defaults
    localparam int TR_NUM = 13;
    localparam logic [3:0] IX_BL_DLY   = 4'h0;
    localparam logic [3:0] IX_BL_WID   = 4'h1;
    localparam logic [3:0] IX_UNUSED_A = 4'h2;
    localparam logic [3:0] IX_N_CMD    = 4'h3;
    localparam logic [3:0] IX_N_WS     = 4'h4;
    localparam logic [3:0] IX_WIO_WS   = 4'h5;
    localparam logic [3:0] IX_WMEM_CMD = 4'h6;
    localparam logic [3:0] IX_WMEM_WS  = 4'h7;
    localparam logic [3:0] IX_ZW_MIN   = 4'h8;
    localparam logic [3:0] IX_LRD_WS   = 4'h9;
    localparam logic [3:0] IX_LWR_WS   = 4'hA;
    localparam logic [3:0] IX_UNUSED_B = 4'hB;
    localparam logic [3:0] IX_LIO_CMD  = 4'hC;
    localparam logic [3:0] BL_WID_MIN  = 4'h1;
    localparam logic [3:0] TR_MASK2    = 4'h3;
    localparam logic [4*TR_NUM-1:0] TR_RST = {
        4'h1, 4'h0, 4'h1, 4'h1, 4'h0, 4'h1,
        4'h0, 4'h1, 4'h4, 4'h1, 4'h0, 4'h1, 4'h0};
    // ========================================================
    // Timing
    localparam int  CLK_NS        = 20;
    localparam int  CP_RST_NS     = 80;
    localparam int  CP_RST_CYC    = (CP_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] CP_RST_LEN = 3'(CP_RST_CYC);
    localparam logic [5:0] SYNC_EXTRA = 6'h2;
    typedef enum logic [2:0] {
        CTR_IDLE, CTR_DELAY, CTR_CMD, CTR_HOLD, CTR_DONE
    } ctr_state_e;
endpackage

// *** verif/ctr_host.sv ***
// Host processor model issuing single-cycle I/O port accesses.
// Assumes the block samples strobes on the rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
module ctr_host
    import ctr_pkg::*;
(
    input  wire logic       ref_clk,    // System clock
    input  wire logic [1:0] rd_data_hi, // Read data bits 7:6
    input  wire logic       rd_data_oe, // Read data driven
    output logic      [7:0] io_addr,    // Port address
    output logic      [7:0] io_wdata,   // Write data
    output logic            io_wr,      // Write strobe
    output logic            io_rd       // Read strobe
);
    initial begin
        io_addr  = 8'h00;
        io_wdata = 8'h00;
        io_wr    = 1'h0;
        io_rd    = 1'h0;
    end
    // ========================================================
    // Port accesses; released lines show the inverse value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'h1;
        @(posedge ref_clk);
        #1;
        io_wr    = 1'h0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic oe,
                      output logic [1:0] d);
        oe = 1'h0;
        d  = 2'h0;
        @(posedge ref_clk);
        #1;
        io_addr = a;
        io_rd   = 1'h1;
        @(posedge ref_clk);
        #1;
        io_rd   = 1'h0;
        io_addr = ~a;
        repeat (2) begin
            if (rd_data_oe === 1'h1) begin
                oe = 1'h1;
                d  = rd_data_hi;
            end
            @(posedge ref_clk);
            #1;
        end
    endtask
    // ========================================================
    // Register helpers
    task automatic unlock(input logic [7:0] d);
        wr(ADDR_SPEED, {1'h0, d[6:0]});
        wr(ADDR_SPEED, {1'h0, d[6:0]});
    endtask
    task automatic tr(input logic [3:0] ix, input logic [3:0] v);
        wr(ADDR_POINTER, {ix[3:2], 2'h0, ix[1:0], 2'h0});
        wr(ADDR_TIMING, {4'h0, v});
    endtask
    task automatic clr_err(input int b);
        wr(ADDR_ERR_CTL, 8'(1 << b));
        wr(ADDR_ERR_CTL, 8'h00);
    endtask
endmodule
`default_nettype wire

// *** verif/cycle_timing_registers_test.sv ***
// Self-checking bench for the cycle timing register bank.
// Assumes ctr_host drives the I/O side; this bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
module cycle_timing_registers_test;
    import ctr_pkg::*;
    logic ref_clk, rst_b, io_wr, io_rd, rd_data_oe, parity_err, chan_check;
    logic [7:0] io_addr, io_wdata;
    logic [1:0] rd_data_hi, cpu_speed_sel, dma_speed_sel;
    logic nmi_out, main_clk_en, aux_clk_en, copro_busy_b, copro_error_b;
    logic cpu_busy_out_b, copro_reset, cyc_start, cyc_mem, cyc_read;
    logic local_board_select, mem_wide_select, io_wide_select;
    logic zero_wait_request, channel_ready, bus_latch_strobe, bus_mem_read;
    logic bus_mem_write, bus_io_read, bus_io_write, cyc_ready, oe;
    logic [1:0] rdv;
    int err_count, cmp_count, cycles, last_n, last_sf, last_sw, k;
    ctr_cycle_regs ctr_cycle_regs_inst (.*);
    ctr_host ctr_host_inst (.ref_clk(ref_clk), .rd_data_hi(rd_data_hi),
        .rd_data_oe(rd_data_oe), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd));
    // ========================================================
    // Clock, timeout and checking
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Kind is {mem, read, local, wide mem, wide io}; length from start edge
    task automatic cyc(input logic [4:0] kd, input int en,
                       input logic [3:0] ec);
        logic [3:0] c;
        c = 4'h0;
        last_n = 1;
        last_sf = 0;
        last_sw = 0;
        @(posedge ref_clk);
        #1;
        {cyc_mem, cyc_read, local_board_select, mem_wide_select,
         io_wide_select} = kd;
        cyc_start = 1'h1;
        @(posedge ref_clk);
        #1;
        cyc_start = 1'h0;
        while (cyc_ready !== 1'h1 && last_n < 200) begin
            if (bus_latch_strobe === 1'h1) begin
                if (last_sw == 0) last_sf = last_n;
                last_sw++;
            end
            c |= {bus_mem_read, bus_mem_write, bus_io_read, bus_io_write};
            @(posedge ref_clk);
            #1;
            last_n++;
        end
        if (en != 0) chk("cycle length", 8'(last_n), 8'(en));
        if (ec != 4'h0) chk("command", 8'(c), 8'(ec));
    endtask
    task automatic pulse_err();
        @(posedge ref_clk);
        #1;
        parity_err = 1'h1;
        @(posedge ref_clk);
        #1;
        parity_err = 1'h0;
    endtask
    // ========================================================
    // Main sequence
    initial begin
        {rst_b, parity_err, chan_check, cyc_start, cyc_mem, cyc_read} = 6'h00;
        {local_board_select, mem_wide_select, io_wide_select} = 3'h0;
        {zero_wait_request, copro_busy_b, copro_error_b} = 3'h3;
        channel_ready = 1'h1;
        repeat (20) @(posedge ref_clk);
        #1;
        rst_b = 1'h1;
        chk("cpu speed", 8'(cpu_speed_sel), 8'h00);
        chk("clocks", 8'({main_clk_en, aux_clk_en}), 8'h03);
        cyc(5'h00, 12, 4'h1);
        chk("strobe", 8'({4'(last_sf), 4'(last_sw)}), 8'h11);
        ctr_host_inst.tr(4'h4, 4'h7);
        cyc(5'h00, 12, 4'h1);
        ctr_host_inst.wr(ADDR_SPEED, 8'h04);
        chk("locked speed", 8'(cpu_speed_sel), 8'h00);
        ctr_host_inst.wr(ADDR_SPEED, 8'h06);
        chk("fast speed", 8'(cpu_speed_sel), 8'h01);
        chk("dma speed", 8'(dma_speed_sel), 8'h02);
        cyc(5'h00, 14, 4'h1);
        ctr_host_inst.wr(ADDR_SPEED, 8'h40);
        chk("stop", 8'({main_clk_en, aux_clk_en}), 8'h01);
        ctr_host_inst.wr(ADDR_SPEED, 8'h84);
        chk("lock set", 8'({main_clk_en, cpu_speed_sel}), 8'h00);
        ctr_host_inst.unlock(8'h00);
        chk("slow run", 8'({main_clk_en, cpu_speed_sel}), 8'h04);
        ctr_host_inst.tr(4'h0, 4'h2);
        ctr_host_inst.tr(4'h1, 4'h3);
        ctr_host_inst.tr(4'h3, 4'h3);
        ctr_host_inst.tr(4'h4, 4'h2);
        cyc(5'h08, 10, 4'h2);
        chk("strobe", 8'({4'(last_sf), 4'(last_sw)}), 8'h33);
        ctr_host_inst.tr(4'h2, 4'hF);
        ctr_host_inst.tr(4'hB, 4'hF);
        cyc(5'h08, 10, 4'h2);
        ctr_host_inst.tr(4'h5, 4'h3);
        cyc(5'h01, 12, 4'h1);
        ctr_host_inst.tr(4'h6, 4'h2);
        ctr_host_inst.tr(4'h7, 4'h0);
        cyc(5'h1A, 5, 4'h8);
        ctr_host_inst.tr(4'h9, 4'h2);
        ctr_host_inst.tr(4'hA, 4'h3);
        cyc(5'h1C, 7, 4'h8);
        cyc(5'h14, 9, 4'h4);
        ctr_host_inst.tr(4'hC, 4'h2);
        cyc(5'h0C, 9, 4'h2);
        channel_ready = 1'h0;
        fork
            cyc(5'h0C, 0, 4'h2);
            begin
                repeat (20) @(posedge ref_clk);
                #1;
                channel_ready = 1'h1;
            end
        join
        chk("stretch", 8'(last_n > 18), 8'h01);
        zero_wait_request = 1'h1;
        cyc(5'h08, 0, 4'h2);
        chk("zero wait early", 8'(last_n < 10), 8'h01);
        ctr_host_inst.tr(4'h8, 4'h1);
        cyc(5'h08, 8, 4'h2);
        ctr_host_inst.tr(4'h8, 4'h4);
        cyc(5'h08, 10, 4'h2);
        zero_wait_request = 1'h0;
        ctr_host_inst.wr(ADDR_ERR_CTL, 8'h00);
        pulse_err();
        chk("nmi masked", 8'(nmi_out), 8'h00);
        ctr_host_inst.wr(ADDR_NMI_MASK, 8'h00);
        chk("nmi parity", 8'(nmi_out), 8'h01);
        ctr_host_inst.rd(ADDR_ERR_CTL, oe, rdv);
        chk("read parity", 8'({oe, rdv}), 8'h06);
        ctr_host_inst.wr(ADDR_NMI_MASK, 8'h80);
        chk("nmi off", 8'(nmi_out), 8'h00);
        ctr_host_inst.wr(ADDR_NMI_MASK, 8'h00);
        ctr_host_inst.clr_err(ERR_PAR_DIS_BIT);
        ctr_host_inst.rd(ADDR_ERR_CTL, oe, rdv);
        chk("parity clr", 8'({nmi_out, oe, rdv}), 8'h04);
        chan_check = 1'h1;
        ctr_host_inst.rd(ADDR_ERR_CTL, oe, rdv);
        chk("read chan", 8'({nmi_out, oe, rdv}), 8'h0D);
        chan_check = 1'h0;
        ctr_host_inst.clr_err(ERR_CHK_DIS_BIT);
        ctr_host_inst.rd(8'h62, oe, rdv);
        chk("unmapped read", 8'({nmi_out, oe}), 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            #1;
            {copro_busy_b, copro_error_b} = 2'h0;
            @(posedge ref_clk);
            #1;
            {copro_busy_b, copro_error_b} = 2'h3;
            repeat (2) @(posedge ref_clk);
            #1;
            chk("busy latched", 8'(cpu_busy_out_b), 8'h00);
            ctr_host_inst.wr(i == 0 ? ADDR_BSY_CLR : ADDR_CP_RST, 8'hA5);
            k = int'(copro_reset);
            repeat (8) begin
                @(posedge ref_clk);
                #1;
                k += int'(copro_reset);
            end
            chk("copro reset", 8'(k), i == 0 ? 8'h00 : 8'h04);
            chk("busy free", 8'(cpu_busy_out_b), 8'h01);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
